//--- hw/vcl_ctrl.sv
// oscillator calibration, lock filtering and upset-tolerant loop control
//
// Chosen here: the address map and the APB register port.
module vcl_ctrl #(
  parameter int CAL_STEP_CYCLES = vcl_pkg::CAL_STEP_CYC,
  parameter int LOCK_ACQ_CYCLES = vcl_pkg::LOCK_ACQ_CYC
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [vcl_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [vcl_pkg::DATA_W-1:0]      pwdata,
  output logic      [vcl_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            ratio_sel,
  input  wire logic                            manual_tuning_select,
  input  wire logic                            relock_on_loss_enable,
  input  wire logic [vcl_pkg::PIN_RANGE_W-1:0] vcxo_range_pins,
  input  wire logic                            ext_reset_n,
  input  wire logic                            single_ended_ref_in,
  input  wire logic                            differential_ref_in,
  input  wire logic                            pll_lock_raw,
  input  wire logic                            vcxo_osc,
  output logic      [vcl_pkg::CODE_W-1:0]      vcxo_range_code,
  output logic                                 vcxo_fine_sel,
  output logic                                 ref_clk_out,
  output logic                                 cal_active,
  output logic                                 locked,
  output logic                                 error,
  output logic                                 clk_hi_out,
  output logic                                 clk_mid_out,
  output logic                                 clk_lo_out
);
  import vcl_pkg::*;

  // pin synchroniser
  logic [SYNC_W-1:0]      sync1_ff;
  logic [SYNC_W-1:0]      sync2_ff;
  logic                   ratio_s;
  logic                   manual_s;
  logic                   relock_s;
  logic [PIN_RANGE_W-1:0] range_s;
  logic                   ext_rst_s;
  logic                   se_ref_s;
  logic                   diff_ref_s;
  logic                   lock_raw_s;
  logic                   osc_s;

  // triplicated loop control
  vcl_state_t             st_ff [TMR_N];
  logic [CODE_W-1:0]      code_ff [TMR_N];
  logic [2:0]             st_vote_bits;
  vcl_state_t             st_v;
  logic [CODE_W-1:0]      code_v;
  vcl_state_t             nxt_st;
  logic [CODE_W-1:0]      nxt_code;
  logic                   mismatch;

  // timers, filter, outputs
  logic [TIMER_W-1:0]     timer_ff;
  logic [TIMER_W-1:0]     nxt_timer;
  logic [FLT_W-1:0]       flt_cnt_ff;
  logic [FLT_W-1:0]       nxt_flt_cnt;
  logic                   flt_lock_ff;
  logic                   nxt_flt_lock;
  logic [FLT_W-1:0]       flt_len;
  logic [CODE_W-1:0]      range_ff;
  logic                   fine_ff;
  logic                   ref_ff;
  logic                   locked_ff;
  logic                   err_ff;
  logic                   cal_ff;

  // register file
  logic [FLT_W-1:0]       flt_thr_ff;
  logic [ERRCNT_W-1:0]    errcnt_ff;
  logic [ERRCNT_W-1:0]    nxt_errcnt;
  logic [DATA_W-1:0]      rdata_ff;
  logic [DATA_W-1:0]      rd_mux;
  logic [DATA_W-1:0]      status_word;
  logic                   setup_ph;
  logic                   access_wr;
  logic                   hit_ctrl;
  logic                   hit_status;
  logic                   hit_errcnt;
  logic                   addr_ok;
  logic                   recal_req;

  // decoded conditions
  logic [1:0]             op_mode;
  logic                   auto_mode;
  logic                   ref_comb;
  logic [CODE_W-1:0]      manual_code;
  logic                   step_done;
  logic                   acq_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {ratio_sel, manual_tuning_select, relock_on_loss_enable,
                   vcxo_range_pins, ext_reset_n, single_ended_ref_in,
                   differential_ref_in, pll_lock_raw, vcxo_osc};
      sync2_ff <= sync1_ff;
    end
  end

  assign {ratio_s, manual_s, relock_s, range_s, ext_rst_s, se_ref_s,
          diff_ref_s, lock_raw_s, osc_s} = sync2_ff;

  assign ref_comb    = se_ref_s | diff_ref_s;
  assign op_mode     = manual_s ? MODE_MANUAL :
                       (relock_s ? MODE_RELOCK : MODE_HOLD);
  assign auto_mode   = !manual_s;
  assign manual_code = {ext_rst_s, relock_s, range_s};

  // majority vote over the three copies
  assign st_vote_bits = (st_ff[0] & st_ff[1]) | (st_ff[0] & st_ff[2]) |
                        (st_ff[1] & st_ff[2]);
  assign st_v         = vcl_state_t'(st_vote_bits);
  assign code_v       = (code_ff[0] & code_ff[1]) | (code_ff[0] & code_ff[2])
                      | (code_ff[1] & code_ff[2]);
  assign mismatch     = (st_ff[0] != st_ff[1]) || (st_ff[0] != st_ff[2]) ||
                        (code_ff[0] != code_ff[1]) ||
                        (code_ff[0] != code_ff[2]);

  assign step_done = (timer_ff >= TIMER_W'(CAL_STEP_CYCLES - 1));
  assign acq_done  = (timer_ff >= TIMER_W'(LOCK_ACQ_CYCLES - 1));

  // calibration and lock sequencing
  always_comb begin
    nxt_st    = st_v;
    nxt_code  = code_v;
    nxt_timer = timer_ff + TIMER_W'(1);
    if (!auto_mode) begin
      nxt_st    = VCL_ST_MAN;
      nxt_timer = '0;
    end else if (!ext_rst_s) begin
      nxt_st    = VCL_ST_RSTW;
      nxt_timer = '0;
    end else if (recal_req) begin
      nxt_st    = VCL_ST_CAL;
      nxt_code  = '0;
      nxt_timer = '0;
    end else begin
      case (st_v)
        VCL_ST_RSTW, VCL_ST_MAN: begin
          nxt_st    = VCL_ST_CAL;
          nxt_code  = '0;
          nxt_timer = '0;
        end
        VCL_ST_CAL: begin
          if (step_done) begin
            nxt_timer = '0;
            if (lock_raw_s) begin
              nxt_st = VCL_ST_ACQ;
            end else begin
              nxt_code = code_v + CODE_W'(1);
            end
          end
        end
        VCL_ST_ACQ: begin
          if (flt_lock_ff) begin
            nxt_st    = VCL_ST_LOCK;
            nxt_timer = '0;
          end else if (acq_done) begin
            nxt_timer = '0;
            if (relock_s) begin
              nxt_st   = VCL_ST_CAL;
              nxt_code = '0;
            end
          end
        end
        VCL_ST_LOCK: begin
          nxt_timer = '0;
          if (!flt_lock_ff) begin
            if (relock_s) begin
              nxt_st   = VCL_ST_CAL;
              nxt_code = '0;
            end else begin
              nxt_st = VCL_ST_ACQ;
            end
          end
        end
        default: begin
          nxt_st    = VCL_ST_RSTW;
          nxt_timer = '0;
        end
      endcase
    end
  end

  // each copy reloads from the voted next value
  for (genvar g = 0; g < TMR_N; g++) begin : g_tmr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_ff[g]   <= VCL_ST_RSTW;
        code_ff[g] <= '0;
      end else begin
        st_ff[g]   <= nxt_st;
        code_ff[g] <= nxt_code;
      end
    end
  end

  // lock filter: flips only after a run of opposite raw samples
  assign flt_len = (flt_thr_ff == '0) ? FLT_W'(1) : flt_thr_ff;

  always_comb begin
    nxt_flt_cnt  = flt_cnt_ff + FLT_W'(1);
    nxt_flt_lock = flt_lock_ff;
    if (lock_raw_s == flt_lock_ff) begin
      nxt_flt_cnt = '0;
    end else if (nxt_flt_cnt >= flt_len) begin
      nxt_flt_cnt  = '0;
      nxt_flt_lock = lock_raw_s;
    end
  end

  // upset counter, an event in the same cycle as a software clear leaves the count at 1, or at 0 when the count was saturated
  always_comb begin
    nxt_errcnt = errcnt_ff;
    if (access_wr && hit_errcnt) begin
      nxt_errcnt = '0;
    end
    if (mismatch && !err_ff && (errcnt_ff != '1)) begin
      nxt_errcnt = (access_wr && hit_errcnt) ? ERRCNT_W'(1)
                                             : errcnt_ff + ERRCNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff    <= '0;
      flt_cnt_ff  <= '0;
      flt_lock_ff <= 1'b0;
      range_ff    <= '0;
      fine_ff     <= 1'b0;
      ref_ff      <= 1'b0;
      locked_ff   <= 1'b0;
      err_ff      <= 1'b0;
      cal_ff      <= 1'b0;
      errcnt_ff   <= '0;
    end else begin
      timer_ff    <= nxt_timer;
      flt_cnt_ff  <= nxt_flt_cnt;
      flt_lock_ff <= nxt_flt_lock;
      range_ff    <= manual_s ? manual_code : code_v;
      fine_ff     <= manual_s & ref_comb;
      ref_ff      <= ref_comb;
      locked_ff   <= manual_s ? lock_raw_s : flt_lock_ff;
      err_ff      <= mismatch;
      cal_ff      <= (nxt_st == VCL_ST_CAL);
      errcnt_ff   <= nxt_errcnt;
    end
  end

  // apb slave, zero wait states, read data captured in setup
  assign setup_ph   = psel && !penable;
  assign hit_ctrl   = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_errcnt = (paddr == ADDR_ERRCNT);
  assign addr_ok    = hit_ctrl || hit_status || hit_errcnt;
  assign access_wr  = psel && penable && pwrite && addr_ok;
  assign recal_req  = access_wr && hit_ctrl && pwdata[CTRL_RECAL_BIT];

  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 3]      = st_v;
    status_word[ST_FLOCK_BIT]           = flt_lock_ff;
    status_word[ST_RLOCK_BIT]           = lock_raw_s;
    status_word[ST_MODE_LSB +: 2]       = op_mode;
    status_word[ST_ERR_BIT]             = err_ff;
    status_word[ST_CODE_LSB +: CODE_W]  = range_ff;
    status_word[ST_CAL_BIT]             = cal_ff;
    status_word[ST_REF_BIT]             = ref_comb;
  end

  assign rd_mux = hit_ctrl   ? {{(DATA_W-FLT_W){1'b0}}, flt_thr_ff} :
                  hit_status ? status_word :
                  hit_errcnt ? {{(DATA_W-ERRCNT_W){1'b0}}, errcnt_ff} :
                  '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_thr_ff <= FLT_RESET;
      rdata_ff   <= '0;
    end else begin
      if (setup_ph) begin
        rdata_ff <= rd_mux;
      end
      if (access_wr && hit_ctrl) begin
        flt_thr_ff <= pwdata[CTRL_FLT_LSB +: FLT_W];
      end
    end
  end

  assign prdata  = rdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  vcl_clk_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .osc_s     (osc_s),
    .ratio_sel (ratio_s),
    .clk_hi    (clk_hi_out),
    .clk_mid   (clk_mid_out),
    .clk_lo    (clk_lo_out)
  );

  assign vcxo_range_code = range_ff;
  assign vcxo_fine_sel   = fine_ff;
  assign ref_clk_out     = ref_ff;
  assign cal_active      = cal_ff;
  assign locked          = locked_ff;
  assign error           = err_ff;
endmodule

//--- shared/vcl_pkg.sv
// constants, types and register map of the oscillator calibration block
package vcl_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RANGE_CODES    = 64;
  localparam int CAL_TOTAL_MS   = 180;
  localparam int LOCK_ACQ_US    = 250;
  localparam int CAL_STEP_NS    = (CAL_TOTAL_MS * 1000000) / RANGE_CODES;
  localparam int CAL_STEP_CYC   = CAL_STEP_NS / CLK_PERIOD_NS;
  localparam int LOCK_ACQ_CYC   = (LOCK_ACQ_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 20;

  // widths
  localparam int CODE_W         = 6;
  localparam int PIN_RANGE_W    = 4;
  localparam int SYNC_W         = 12;
  localparam int TMR_N          = 3;
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  localparam int FLT_W          = 8;
  localparam int ERRCNT_W       = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERRCNT = 8'h08;

  // control register fields
  localparam int CTRL_FLT_LSB   = 0;
  localparam int CTRL_RECAL_BIT = 8;
  localparam logic [7:0] FLT_RESET = 8'h10;

  // status register fields
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_FLOCK_BIT   = 3;
  localparam int ST_RLOCK_BIT   = 4;
  localparam int ST_MODE_LSB    = 5;
  localparam int ST_ERR_BIT     = 7;
  localparam int ST_CODE_LSB    = 8;
  localparam int ST_CAL_BIT     = 14;
  localparam int ST_REF_BIT     = 15;

  // divider counts in oscillator edges
  localparam logic [2:0] DIV_EDGES_X3 = 3'h5;
  localparam logic [2:0] DIV_EDGES_X4 = 3'h7;

  // operating modes
  localparam logic [1:0] MODE_HOLD   = 2'h0;
  localparam logic [1:0] MODE_RELOCK = 2'h1;
  localparam logic [1:0] MODE_MANUAL = 2'h2;

  typedef enum logic [2:0] {
    VCL_ST_RSTW = 3'b000,
    VCL_ST_CAL  = 3'b001,
    VCL_ST_ACQ  = 3'b011,
    VCL_ST_LOCK = 3'b010,
    VCL_ST_MAN  = 3'b110
  } vcl_state_t;

endpackage

//--- hw/vcl_clk_div.sv
// synchronous divider producing the three output clocks from the oscillator
module vcl_clk_div (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic osc_s,
  input  wire logic ratio_sel,
  output logic      clk_hi,
  output logic      clk_mid,
  output logic      clk_lo
);
  import vcl_pkg::*;

  logic       osc_d_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] last_cnt;
  logic       osc_edge;
  logic       hi_ff;
  logic       mid_ff;
  logic       lo_ff;
  logic       nxt_mid;
  logic       nxt_lo;

  assign osc_edge = osc_s ^ osc_d_ff;
  assign last_cnt = ratio_sel ? DIV_EDGES_X4 : DIV_EDGES_X3;
  assign nxt_cnt  = (cnt_ff >= last_cnt) ? 3'h0 : cnt_ff + 3'h1;

  // x4 ratio: /2 and /4; x3 ratio: /1.5 (uneven duty) and /3
  assign nxt_mid = ratio_sel ? ~nxt_cnt[1] :
                   ((nxt_cnt == 3'h0) || (nxt_cnt == 3'h3));
  assign nxt_lo  = ratio_sel ? (nxt_cnt < 3'h4) : (nxt_cnt < 3'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_ff <= 1'b0;
      cnt_ff   <= 3'h0;
      hi_ff    <= 1'b0;
      mid_ff   <= 1'b0;
      lo_ff    <= 1'b0;
    end else begin
      osc_d_ff <= osc_s;
      hi_ff    <= osc_s; // highest clock straight from oscillator
      if (osc_edge) begin
        cnt_ff <= nxt_cnt;
        mid_ff <= nxt_mid;
        lo_ff  <= nxt_lo;
      end
    end
  end

  assign clk_hi  = hi_ff;
  assign clk_mid = mid_ff;
  assign clk_lo  = lo_ff;
endmodule

//--- sim/vcl_ctrl_props.sv
// assertions on the calibration and lock block ports
module vcl_ctrl_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       manual_tuning_select,
  input wire logic       relock_on_loss_enable,
  input wire logic [3:0] vcxo_range_pins,
  input wire logic       ext_reset_n,
  input wire logic       single_ended_ref_in,
  input wire logic       differential_ref_in,
  input wire logic       pll_lock_raw,
  input wire logic [5:0] vcxo_range_code,
  input wire logic       vcxo_fine_sel,
  input wire logic       ref_clk_out,
  input wire logic       cal_active,
  input wire logic       locked,
  input wire logic       error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       am = !manual_tuning_select;
  wire       rf = single_ended_ref_in | differential_ref_in;
  wire [5:0] mc = {ext_reset_n, relock_on_loss_enable, vcxo_range_pins};
  sequence s_man; manual_tuning_select [*6]; endsequence
  sequence s_auto; (am && ext_reset_n) [*8]; endsequence
  sequence s_rel; am && !ext_reset_n ##1 am && ext_reset_n; endsequence
  property p_ready; psel && penable |-> pready; endproperty
  property p_no_cal; s_man |-> !cal_active; endproperty
  property p_code;
    (manual_tuning_select && $stable(mc)) [*6] |-> vcxo_range_code == mc;
  endproperty
  property p_raw; s_man |-> locked == $past(pll_lock_raw, 3); endproperty
  property p_filt;
    s_auto ##0 $changed(locked) |->
      locked == $past(pll_lock_raw, 5) && locked == $past(pll_lock_raw, 9);
  endproperty
  property p_ref; (rf [*4] |-> ref_clk_out) and (!rf [*4] |-> !ref_clk_out);
  endproperty
  property p_fine;
    ((manual_tuning_select && rf) [*6] |-> vcxo_fine_sel) and
    ((manual_tuning_select && !rf) [*6] |-> !vcxo_fine_sel);
  endproperty
  property p_cal_rst; s_rel |-> ##[1:8] cal_active; endproperty
  property p_relock;
    s_auto ##0 (relock_on_loss_enable && $fell(locked)) |-> ##[0:4] cal_active;
  endproperty
  property p_hold;
    (am && !relock_on_loss_enable && ext_reset_n) [*8] |-> !$rose(cal_active);
  endproperty
  property p_step;
    cal_active && $past(cal_active) && $past(cal_active, 2) &&
      $changed(vcxo_range_code) |->
      vcxo_range_code == $past(vcxo_range_code) + 6'h01;
  endproperty
  property p_err; error |-> ##[1:4] !error; endproperty
  a_ready: assert property (p_ready)
    else $error("apb access stalled");
  a_no_cal: assert property (p_no_cal)
    else $error("calibration while manual");
  a_code: assert property (p_code)
    else $error("manual range code wrong");
  a_raw: assert property (p_raw)
    else $error("manual lock not raw");
  a_filt: assert property (p_filt)
    else $error("lock flipped without filter");
  a_ref: assert property (p_ref)
    else $error("reference not ored");
  a_fine: assert property (p_fine)
    else $error("fine select wrong");
  a_cal_rst: assert property (p_cal_rst)
    else $error("no calibration after reset");
  a_relock: assert property (p_relock)
    else $error("no calibration on loss");
  a_hold: assert property (p_hold)
    else $error("calibration with relock off");
  a_step: assert property (p_step)
    else $error("range code skipped");
  a_err: assert property (p_err)
    else $error("error flag held");
endmodule

bind vcl_ctrl vcl_ctrl_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .manual_tuning_select(manual_tuning_select),
  .relock_on_loss_enable(relock_on_loss_enable),
  .vcxo_range_pins(vcxo_range_pins), .ext_reset_n(ext_reset_n),
  .single_ended_ref_in(single_ended_ref_in),
  .differential_ref_in(differential_ref_in), .pll_lock_raw(pll_lock_raw),
  .vcxo_range_code(vcxo_range_code), .vcxo_fine_sel(vcxo_fine_sel),
  .ref_clk_out(ref_clk_out), .cal_active(cal_active), .locked(locked),
  .error(error)
);

//--- sim/vcl_ref_model.sv
// reference source, oscillator and loop lock seen from the board
module vcl_ref_model (
  input  wire logic       pclk,
  input  wire logic       use_diff,
  input  wire logic       ref_on,
  input  wire logic       ref_lvl,
  input  wire logic       dip,
  input  wire logic [5:0] lock_code,
  input  wire logic [5:0] vcxo_range_code,
  output logic            single_ended_ref_in,
  output logic            differential_ref_in,
  output logic            pll_lock_raw,
  output logic            vcxo_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rdiv_ff = 3'h0;
  logic [2:0] odiv_ff = 3'h0;
  logic       ref_ff  = 1'b0;
  logic       osc_ff  = 1'b0;
  logic       lock_ff = 1'b0;
  wire        ref_lv  = ref_on ? ref_ff : ref_lvl;
  // unused reference input held low
  assign single_ended_ref_in = use_diff ? 1'b0 : ref_lv;
  assign differential_ref_in = use_diff ? ref_lv : 1'b0;
  assign vcxo_osc     = osc_ff;
  assign pll_lock_raw = lock_ff;
  always @(posedge pclk) begin
    rdiv_ff <= (rdiv_ff == 3'h2) ? 3'h0 : rdiv_ff + 3'h1;
    odiv_ff <= (odiv_ff == 3'h4) ? 3'h0 : odiv_ff + 3'h1;
    if (rdiv_ff == 3'h2) ref_ff <= !ref_ff;
    if (odiv_ff == 3'h4) osc_ff <= !osc_ff;
    lock_ff <= ref_on && (vcxo_range_code == lock_code) && !dip;
  end
endmodule

//--- sim/vcl_ctrl_tb_top.sv
// self-checking bench for the calibration and lock block
module vcl_ctrl_tb_top
  import vcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        ratio    = 1'b1;
  logic        man      = 1'b0;
  logic        relock   = 1'b1;
  logic [3:0]  pins     = 4'h0;
  logic        ext_n    = 1'b1;
  logic        use_diff = 1'b1;
  logic        ref_on   = 1'b1;
  logic        ref_lvl  = 1'b0;
  logic        dip      = 1'b0;
  logic [5:0]  tgt      = 6'h05;
  logic        seen;
  logic [64:0] note;
  logic [64:0] q[$];
  wire  [31:0] prdata;
  wire  [5:0]  code;
  wire         pready, pslverr, se, df, raw, osc, fine, refo, cal, lck;
  wire         err, chi, cmi, clo;
  int          n_fail      = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          i, nh, nm, nl, em, el, bh, bm, bl;

  vcl_ctrl #(.CAL_STEP_CYCLES(20), .LOCK_ACQ_CYCLES(30)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ratio_sel(ratio),
    .manual_tuning_select(man), .relock_on_loss_enable(relock),
    .vcxo_range_pins(pins), .ext_reset_n(ext_n), .single_ended_ref_in(se),
    .differential_ref_in(df), .pll_lock_raw(raw), .vcxo_osc(osc),
    .vcxo_range_code(code), .vcxo_fine_sel(fine), .ref_clk_out(refo),
    .cal_active(cal), .locked(lck), .error(err), .clk_hi_out(chi),
    .clk_mid_out(cmi), .clk_lo_out(clo)
  );
  vcl_ref_model i_ref (
    .pclk(pclk), .use_diff(use_diff), .ref_on(ref_on), .ref_lvl(ref_lvl),
    .dip(dip), .lock_code(tgt), .vcxo_range_code(code),
    .single_ended_ref_in(se), .differential_ref_in(df),
    .pll_lock_raw(raw), .vcxo_osc(osc)
  );

  always #(CLK_PERIOD_NS / 2) pclk = !pclk;
  always @(posedge chi) nh++;
  always @(posedge cmi) nm++;
  always @(posedge clo) nl++;

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the note holds {slverr, mask, expected data}
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    q.push_back({e, m, d & m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_for(input logic s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge pclk);
      if ((s ? cal : lck) === v) break;
    end
    chk({31'h0, (s ? cal : lck) === v}, 32'h1);
  endtask

  task automatic relock_wait();
    wait_for(1'b1, 1'b1, 3000);
    wait_for(1'b1, 1'b0, 3000);
    wait_for(1'b0, 1'b1, 3000);
  endtask

  function automatic logic near(input int a, input int b);
    return ((a > b) ? a - b : b - a) <= 1;
  endfunction

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
    if (psel && penable && pready && q.size() > 0) begin
      note = q.pop_front();
      check_count++;
      if ((prdata & note[63:32]) !== note[31:0] || pslverr !== note[64]) begin
        n_fail++;
        $display("[FAIL] %0t apb read %h", $time, prdata);
      end
    end
  end

  initial begin
    void'($urandom(15402));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h10, 32'h1FF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h05, 32'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h05, 32'h1FF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h10, 32'h0, 1'b0);
    apb(1'b1, ADDR_ERRCNT, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_ERRCNT, 32'h0, 32'hFF, 1'b0);
    apb(1'b1, 8'h0C, 32'h3F, 32'h0, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h20, 32'h60, 1'b0);
    wait_for(1'b0, 1'b1, 3000);
    apb(1'b0, ADDR_STATUS, 32'h053A, 32'h7FFF, 1'b0);
    dip <= 1'b1;
    repeat (8) @(posedge pclk);
    dip <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({31'h0, lck}, 32'h1);
    tgt <= 6'h09;
    relock_wait();
    apb(1'b0, ADDR_STATUS, 32'h093A, 32'h7FFF, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h110, 32'h0, 1'b0);
    relock_wait();
    relock <= 1'b0;
    tgt <= 6'h0C;
    wait_for(1'b0, 1'b0, 100);
    repeat (200) @(posedge pclk);
    chk({31'h0, cal}, 32'h0);
    chk({26'h0, code}, 32'h9);
    tgt <= 6'h09;
    wait_for(1'b0, 1'b1, 60);
    tgt <= 6'h0C;
    ext_n <= 1'b0;
    repeat (10) @(posedge pclk);
    ext_n <= 1'b1;
    relock_wait();
    apb(1'b0, ADDR_STATUS, 32'h0C1A, 32'h7FFF, 1'b0);
    for (i = 0; i < 2; i++) begin
      ratio <= i[0];
      repeat (30) @(posedge pclk);
      bh = nh;
      bm = nm;
      bl = nl;
      repeat (600) @(posedge pclk);
      bh = nh - bh;
      bm = nm - bm;
      bl = nl - bl;
      em = i ? bh / 2 : bh * 2 / 3;
      el = i ? bh / 4 : bh / 3;
      chk({31'h0, near(bh, 60)}, 32'h1);
      chk({31'h0, near(bm, em)}, 32'h1);
      chk({31'h0, near(bl, el)}, 32'h1);
    end
    man <= 1'b1;
    for (i = 0; i < 6; i++) begin
      {ext_n, relock, pins} <= 6'($urandom);
      repeat (8) @(posedge pclk);
      chk({26'h0, code}, {26'h0, ext_n, relock, pins});
      chk({31'h0, cal}, 32'h0);
    end
    apb(1'b0, ADDR_STATUS, {18'h0, code, 8'h46}, 32'h7F67, 1'b0);
    tgt <= code;
    repeat (8) @(posedge pclk);
    dip <= 1'b1;
    @(posedge pclk);
    dip <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      if (lck === 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    ref_on <= 1'b0;
    for (i = 0; i < 4; i++) begin
      ref_lvl <= i[0];
      use_diff <= i[1];
      repeat (8) @(posedge pclk);
      chk({31'h0, fine}, {31'h0, i[0]});
      chk({31'h0, refo}, {31'h0, i[0]});
    end
    chk({31'h0, err}, 32'h0);
    stop_test();
  end
endmodule
